//--- design/dpsf_pkg.sv
// package for the semaphore port controller: pin widths, codes and timing
// assumes a 20 MHz system clock driving one port of the shared semaphore device
package dpsf_pkg;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned SEM_IDX_W = 3;
    localparam int unsigned ADDR_W = 12;
    // access strobe width and recovery gap, in ns
    localparam int unsigned STROBE_NS = 100;
    localparam int unsigned GAP_NS = 50;
    localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 4;
    localparam logic [SEM_IDX_W-1:0] LAST_SEM = 3'h7;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_ONE = 16'h0001;
    // host commands
    typedef enum logic [1:0] {
        DPSF_CMD_CLAIM = 2'b00,
        DPSF_CMD_RELEASE = 2'b01,
        DPSF_CMD_POLL = 2'b10,
        DPSF_CMD_INIT = 2'b11
    } dpsf_cmd_type;
endpackage

//--- design/dpsf_cycle.sv
// one static-RAM style semaphore cycle on the device pins
// assumes the device responds within the strobe time; data is read at strobe end
`timescale 1ns/1ps
module dpsf_cycle #(
    parameter int unsigned STROBE = dpsf_pkg::STROBE_CYC,
    parameter int unsigned GAP = dpsf_pkg::GAP_CYC
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic i_write,
    input wire logic i_wbit,
    input wire logic [dpsf_pkg::SEM_IDX_W-1:0] i_idx,
    input wire logic [dpsf_pkg::DATA_W-1:0] i_data_in,
    output logic o_busy,
    output logic o_done,
    output logic o_rbit,
    output logic o_sem_sel_n,
    output logic o_oe_n,
    output logic o_rw_n,
    output logic o_ce_n,
    output logic [dpsf_pkg::ADDR_W-1:0] o_addr,
    output logic [dpsf_pkg::DATA_W-1:0] o_data_out,
    output logic o_data_oe
);
    logic [dpsf_pkg::CNT_W-1:0] cnt_q;
    logic strobe_q;
    logic gap_q;

    assign o_busy = strobe_q | gap_q;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_q <= '0;
            strobe_q <= 1'b0;
            gap_q <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !o_busy) begin
                strobe_q <= 1'b1;
                cnt_q <= dpsf_pkg::CNT_W'(STROBE - 1);
            end else if (strobe_q) begin
                if (cnt_q == '0) begin
                    strobe_q <= 1'b0;
                    gap_q <= 1'b1;
                    o_done <= 1'b1;
                    cnt_q <= dpsf_pkg::CNT_W'(GAP - 1);
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end else if (gap_q) begin
                if (cnt_q == '0) begin
                    gap_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_sem_sel_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_rw_n <= 1'b1;
            o_ce_n <= 1'b1;
            o_addr <= dpsf_pkg::ADDR_ZERO;
            o_data_out <= dpsf_pkg::DATA_ZERO;
            o_data_oe <= 1'b0;
            o_rbit <= 1'b1;
        end else begin
            o_ce_n <= 1'b1;
            if (i_start && !o_busy) begin
                o_sem_sel_n <= 1'b0;
                o_oe_n <= i_write;
                o_rw_n <= ~i_write;
                o_addr <= {{(dpsf_pkg::ADDR_W - dpsf_pkg::SEM_IDX_W){1'b0}}, i_idx};
                o_data_out <= i_wbit ? dpsf_pkg::DATA_ONE : dpsf_pkg::DATA_ZERO;
                o_data_oe <= i_write;
            end else if (strobe_q && cnt_q == '0) begin
                if (o_rw_n) begin
                    // flag on all bits, bit zero used
                    o_rbit <= i_data_in[0];
                end
                o_sem_sel_n <= 1'b1;
                o_oe_n <= 1'b1;
                o_rw_n <= 1'b1;
                o_data_oe <= 1'b0;
            end
        end
    end
endmodule

//--- design/dpsf_host.sv
// host-side controller for one port of an eight-flag hardware semaphore
// assumes the device pins are synchronous to i_clk and the port uses only semaphores
`timescale 1ns/1ps
// Notes on behaviour
// - flags active low; zero claims, one releases from same side
// - semaphore select low, then ordinary sram address, oe, rw cycle
// - poller must drop select or oe between reads
// - claim is write zero then read back; zero means won
// - after failed claim keep reading or write one to withdraw
// - software writes one to every flag at power up
// - access needs chip enable high and select low
module dpsf_host #(
    parameter int unsigned STROBE = dpsf_pkg::STROBE_CYC,
    parameter int unsigned GAP = dpsf_pkg::GAP_CYC
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_req_valid,
    input wire dpsf_pkg::dpsf_cmd_type i_req_cmd,
    input wire logic [dpsf_pkg::SEM_IDX_W-1:0] i_req_idx,
    input wire logic [dpsf_pkg::DATA_W-1:0] i_data_in,
    output logic o_req_ready,
    output logic o_rsp_valid,
    output logic o_rsp_granted,
    output logic o_init_done,
    output logic o_sem_sel_n,
    output logic o_oe_n,
    output logic o_rw_n,
    output logic o_ce_n,
    output logic [dpsf_pkg::ADDR_W-1:0] o_addr,
    output logic [dpsf_pkg::DATA_W-1:0] o_data_out,
    output logic o_data_oe
);
    typedef enum logic [2:0] {
        DPSF_ST_INIT = 3'b000,
        DPSF_ST_IDLE = 3'b001,
        DPSF_ST_WR = 3'b010,
        DPSF_ST_RD = 3'b011,
        DPSF_ST_DONE = 3'b100
    } dpsf_state_type;

    dpsf_state_type state_q;
    logic [dpsf_pkg::SEM_IDX_W-1:0] idx_q;
    logic wbit_q;
    logic do_read_q;
    logic started_q;
    logic cyc_start;
    logic cyc_write;
    logic cyc_busy;
    logic cyc_done;
    logic cyc_rbit;
    logic sweep_step;
    logic take_req;

    // states that run a pin cycle; started_q limits each WR or RD visit to one, the INIT sweep to one per flag
    function automatic logic launches_cycle(input dpsf_state_type s);
        return s == DPSF_ST_INIT || s == DPSF_ST_WR || s == DPSF_ST_RD;
    endfunction

    assign cyc_start = launches_cycle(state_q) && !started_q && !cyc_busy;
    assign sweep_step = (state_q == DPSF_ST_INIT) && cyc_done;
    assign take_req = (state_q == DPSF_ST_IDLE) && i_req_valid;
    assign cyc_write = (state_q != DPSF_ST_RD);

    dpsf_cycle #(
        .STROBE(STROBE),
        .GAP(GAP)
    ) u_cycle (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_start(cyc_start),
        .i_write(cyc_write),
        .i_wbit(wbit_q),
        .i_idx(idx_q),
        .i_data_in(i_data_in),
        .o_busy(cyc_busy),
        .o_done(cyc_done),
        .o_rbit(cyc_rbit),
        .o_sem_sel_n(o_sem_sel_n),
        .o_oe_n(o_oe_n),
        .o_rw_n(o_rw_n),
        .o_ce_n(o_ce_n),
        .o_addr(o_addr),
        .o_data_out(o_data_out),
        .o_data_oe(o_data_oe)
    );

    // one cycle launched per WR or RD visit, one per flag in INIT
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            started_q <= 1'b0;
        end else if (cyc_start) begin
            started_q <= 1'b1;
        end else if (cyc_done) begin
            started_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= DPSF_ST_INIT;
            wbit_q <= 1'b1;
            do_read_q <= 1'b0;
        end else begin
            case (state_q)
                DPSF_ST_INIT: begin
                    // device state unknown, so write all
                    if (sweep_step && idx_q == dpsf_pkg::LAST_SEM) begin
                        state_q <= DPSF_ST_IDLE;
                    end
                end
                DPSF_ST_IDLE: begin
                    if (i_req_valid) begin
                        case (i_req_cmd)
                            dpsf_pkg::DPSF_CMD_CLAIM: begin
                                wbit_q <= 1'b0;
                                do_read_q <= 1'b1;
                                state_q <= DPSF_ST_WR;
                            end
                            dpsf_pkg::DPSF_CMD_RELEASE: begin
                                wbit_q <= 1'b1;
                                do_read_q <= 1'b0;
                                state_q <= DPSF_ST_WR;
                            end
                            dpsf_pkg::DPSF_CMD_POLL: begin
                                do_read_q <= 1'b1;
                                state_q <= DPSF_ST_RD;
                            end
                            default: begin
                                wbit_q <= 1'b1;
                                state_q <= DPSF_ST_INIT;
                            end
                        endcase
                    end
                end
                DPSF_ST_WR: begin
                    if (cyc_done) begin
                        state_q <= do_read_q ? DPSF_ST_RD : DPSF_ST_DONE;
                    end
                end
                DPSF_ST_RD: begin
                    if (cyc_done) begin
                        state_q <= DPSF_ST_DONE;
                    end
                end
                DPSF_ST_DONE: begin
                    state_q <= DPSF_ST_IDLE;
                end
                default: begin
                    state_q <= DPSF_ST_IDLE;
                end
            endcase
        end
    end

    // flag index: stepped by the sweep, else loaded with a request
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            idx_q <= '0;
        end else if (sweep_step) begin
            idx_q <= idx_q + 1'b1;
        end else if (take_req) begin
            if (i_req_cmd == dpsf_pkg::DPSF_CMD_INIT) begin
                idx_q <= '0;
            end else begin
                idx_q <= i_req_idx;
            end
        end
    end

    // low again on re-init, so callers cannot use half-swept flags
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_init_done <= 1'b0;
        end else if (sweep_step && idx_q == dpsf_pkg::LAST_SEM) begin
            o_init_done <= 1'b1;
        end else if (take_req && i_req_cmd == dpsf_pkg::DPSF_CMD_INIT) begin
            o_init_done <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_req_ready <= 1'b0;
        end else begin
            // low from the cycle after a take until DONE, or for INIT until the sweep ends; a request still held then is taken again
            o_req_ready <= (state_q == DPSF_ST_IDLE && !i_req_valid)
                           || state_q == DPSF_ST_DONE;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rsp_valid <= 1'b0;
        end else begin
            o_rsp_valid <= (state_q == DPSF_ST_DONE);
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rsp_granted <= 1'b0;
        end else if (state_q == DPSF_ST_DONE) begin
            o_rsp_granted <= do_read_q ? ~cyc_rbit : 1'b0;
        end
    end
endmodule

//--- testbench/dpsf_host_props.sv
// pin checker for the semaphore port controller
// assumes the default two-cycle strobe and one-cycle gap
`timescale 1ns/1ps
module dpsf_host_props (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_req_valid,
    input wire dpsf_pkg::dpsf_cmd_type i_req_cmd,
    input wire logic o_req_ready,
    input wire logic o_rsp_valid,
    input wire logic o_sem_sel_n,
    input wire logic o_oe_n,
    input wire logic o_rw_n,
    input wire logic o_ce_n,
    input wire logic [dpsf_pkg::ADDR_W-1:0] o_addr,
    input wire logic [dpsf_pkg::DATA_W-1:0] o_data_out,
    input wire logic o_data_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic take_w;
    assign take_w = i_req_valid && o_req_ready;
    ce_high_a: assert property (o_ce_n)
        else $error("memory array selected");
    addr_upper_a: assert property (o_addr[11:3] == 9'h000)
        else $error("upper address bits set");
    wdata_bit_a: assert property (o_data_oe |-> o_data_out[15:1] == 15'h0000)
        else $error("write data above bit zero");
    write_pins_a: assert property (o_data_oe |-> !o_sem_sel_n && !o_rw_n && o_oe_n)
        else $error("write cycle pins wrong");
    read_pins_a: assert property (!o_oe_n |-> !o_sem_sel_n && o_rw_n && !o_data_oe)
        else $error("read cycle pins wrong");
    strobe_gap_a: assert property ($fell(o_sem_sel_n) |-> !o_sem_sel_n ##1 !o_sem_sel_n ##1 o_sem_sel_n)
        else $error("select strobe or gap length wrong");
    rsp_pulse_a: assert property (o_rsp_valid |=> !o_rsp_valid)
        else $error("response longer than one cycle");
    claim_order_a: assert property (take_w && i_req_cmd == dpsf_pkg::DPSF_CMD_CLAIM |=>
        ##1 !o_rw_n && o_data_out == dpsf_pkg::DATA_ZERO ##4 !o_oe_n && !o_sem_sel_n)
        else $error("claim is not write zero then read");
    release_one_a: assert property (take_w && i_req_cmd == dpsf_pkg::DPSF_CMD_RELEASE |=>
        ##1 !o_rw_n && !o_sem_sel_n && o_data_out == dpsf_pkg::DATA_ONE)
        else $error("release does not write one");
endmodule
bind dpsf_host dpsf_host_props props_u (.i_clk, .i_sys_rst, .i_req_valid, .i_req_cmd,
    .o_req_ready, .o_rsp_valid, .o_sem_sel_n, .o_oe_n, .o_rw_n, .o_ce_n, .o_addr,
    .o_data_out, .o_data_oe);

//--- testbench/dpsf_dev_model.sv
// behavioural eight-flag semaphore device, left port on pins, right port from bench
// assumes pins change just after i_clk edges; no memory array is modelled
`timescale 1ns/1ps
module dpsf_dev_model (
    input wire logic i_clk,
    input wire logic i_sem_sel_n,
    input wire logic i_oe_n,
    input wire logic i_rw_n,
    input wire logic i_ce_n,
    input wire logic [11:0] i_addr,
    input wire logic [15:0] i_data_out,
    input wire logic i_data_oe,
    input wire logic i_r_wr,
    input wire logic [2:0] i_r_idx,
    input wire logic i_r_bit,
    output logic [15:0] o_data,
    output logic [7:0] o_r_view
);
    logic [7:0] rl = 8'h00, rr = 8'h00, lo = 8'h00, ro = 8'h00;
    logic rd_q = 1'b0, lat = 1'b1, tg = 1'b0;
    logic rd, wl;
    logic [2:0] ia;
    assign ia = i_addr[2:0];
    assign rd = !i_sem_sel_n && !i_oe_n && i_rw_n && i_ce_n;
    assign wl = !i_sem_sel_n && !i_rw_n && i_ce_n && i_data_oe;
    // spread and hold; released bus toggles
    assign o_data = rd ? {16{rd_q ? lat : ~lo[ia]}} : {8{tg, ~tg}};
    assign o_r_view = ~ro;
    always @(posedge i_clk) begin
        rd_q <= rd;
        tg <= ~tg;
        if (rd && !rd_q) lat <= ~lo[ia];
        if (wl) rl[ia] = i_data_out[0];
        if (i_r_wr) rr[i_r_idx] = i_r_bit;
        for (int i = 0; i < 8; i++) begin
            if (lo[i] && rl[i]) lo[i] = 1'b0;
            if (ro[i] && rr[i]) ro[i] = 1'b0;
            if (!lo[i] && !ro[i]) begin
                if (!rl[i]) lo[i] = 1'b1;
                else if (!rr[i]) ro[i] = 1'b1;
            end
        end
    end
endmodule

//--- testbench/tb_top.sv
// self-checking bench: host controller on the left port, bench on the right
// assumes the model answers reads at once and pins settle after each edge
`timescale 1ns/1ps
module tb_top;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_req_valid = 1'b0, r_wr = 1'b0, r_bit = 1'b1;
    dpsf_pkg::dpsf_cmd_type i_req_cmd = dpsf_pkg::DPSF_CMD_POLL;
    logic [2:0] i_req_idx = 3'h0, r_idx = 3'h0;
    logic [15:0] din, dout;
    logic [11:0] addr;
    logic [7:0] r_view;
    logic rdy, rv, gr, idn, sel_n, oe_n, rw_n, ce_n, doe, g;
    int err_total = 0, n_tests = 0;
    dpsf_host dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid),
        .i_req_cmd(i_req_cmd), .i_req_idx(i_req_idx), .i_data_in(din), .o_req_ready(rdy),
        .o_rsp_valid(rv), .o_rsp_granted(gr), .o_init_done(idn), .o_sem_sel_n(sel_n),
        .o_oe_n(oe_n), .o_rw_n(rw_n), .o_ce_n(ce_n), .o_addr(addr), .o_data_out(dout),
        .o_data_oe(doe));
    dpsf_dev_model dev_u (.i_clk(i_clk), .i_sem_sel_n(sel_n), .i_oe_n(oe_n), .i_rw_n(rw_n),
        .i_ce_n(ce_n), .i_addr(addr), .i_data_out(dout), .i_data_oe(doe), .i_r_wr(r_wr),
        .i_r_idx(r_idx), .i_r_bit(r_bit), .o_data(din), .o_r_view(r_view));
    initial begin
        forever #25 i_clk = ~i_clk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rwr(input logic [2:0] x, input logic b);
        @(posedge i_clk);
        #2 r_wr = 1'b1;
        r_idx = x;
        r_bit = b;
        @(posedge i_clk);
        #2 r_wr = 1'b0;
    endtask
    // waits stay bounded; the grant is kept from the response cycle
    task automatic req(input dpsf_pkg::dpsf_cmd_type c, input logic [2:0] x, output logic gt);
        int n;
        n = 0;
        gt = 1'b0;
        while (rdy !== 1'b1 && n < 100) begin
            @(posedge i_clk);
            #2 n++;
        end
        if (rdy !== 1'b1) begin
            err_total++;
            stop_test();
        end else begin
            i_req_valid = 1'b1;
            i_req_cmd = c;
            i_req_idx = x;
            @(posedge i_clk);
            #2 i_req_valid = 1'b0;
            while (rdy !== 1'b1 && n < 200) begin
                if (rv === 1'b1) gt = gr;
                @(posedge i_clk);
                #2 n++;
            end
            if (rv === 1'b1) gt = gr;
            if (rdy !== 1'b1) begin
                err_total++;
                stop_test();
            end
        end
    endtask
    task automatic t_init();
        repeat (4) @(posedge i_clk);
        #2 i_sys_rst = 1'b0;
        for (int i = 0; i < 8; i++) rwr(3'(i), 1'b1);
        req(dpsf_pkg::DPSF_CMD_POLL, 3'h0, g);
        check("init_done", {7'h00, idn}, 8'h01);
        check("right views free", r_view, 8'hFF);
        $display("test init done");
    endtask
    task automatic t_hand();
        for (int i = 0; i < 8; i++) begin
            req(dpsf_pkg::DPSF_CMD_CLAIM, 3'(i), g);
            check("claim granted", {7'h00, g}, 8'h01);
        end
        check("right sees taken", r_view, 8'hFF);
        rwr(3'h3, 1'b0);
        req(dpsf_pkg::DPSF_CMD_POLL, 3'h3, g);
        check("owner keeps flag", {7'h00, g}, 8'h01);
        check("pending reads one", {7'h00, r_view[3]}, 8'h01);
        req(dpsf_pkg::DPSF_CMD_RELEASE, 3'h3, g);
        check("pending takes over", r_view, 8'hF7);
        req(dpsf_pkg::DPSF_CMD_CLAIM, 3'h3, g);
        check("claim refused", {7'h00, g}, 8'h00);
        req(dpsf_pkg::DPSF_CMD_RELEASE, 3'h3, g);
        rwr(3'h3, 1'b1);
        check("right released", r_view, 8'hFF);
        for (int i = 0; i < 8; i++) req(dpsf_pkg::DPSF_CMD_RELEASE, 3'(i), g);
        check("all free", r_view, 8'hFF);
        req(dpsf_pkg::DPSF_CMD_POLL, 3'h0, g);
        check("left sees free", {7'h00, g}, 8'h00);
        $display("test hand-over done");
    endtask
    task automatic t_race();
        fork
            req(dpsf_pkg::DPSF_CMD_CLAIM, 3'h5, g);
            rwr(3'h5, 1'b0);
        join
        check("one owner", {7'h00, g ~^ r_view[5]}, 8'h01);
        check("earlier side wins", {7'h00, g}, 8'h00);
        req(dpsf_pkg::DPSF_CMD_RELEASE, 3'h5, g);
        rwr(3'h5, 1'b1);
        req(dpsf_pkg::DPSF_CMD_CLAIM, 3'h2, g);
        req(dpsf_pkg::DPSF_CMD_INIT, 3'h0, g);
        rwr(3'h2, 1'b0);
        check("reinit frees", r_view, 8'hFB);
        check("init_done again", {7'h00, idn}, 8'h01);
        $display("test race and reinit done");
    endtask
    initial begin
        t_init();
        t_hand();
        t_race();
        stop_test();
    end
endmodule
